// ==== design/ibr_pkg.sv ====
package ibr_pkg;

  // ----------------------------------------------------------------
  // status codes
  // ----------------------------------------------------------------
  localparam logic [7:0] STAT_IDLE   = 8'hF8;
  localparam logic [7:0] STAT_BADCNT = 8'hFC;
  localparam logic [7:0] STAT_BERR   = 8'h00;
  localparam logic [7:0] STAT_SDALOW = 8'h70;
  localparam logic [7:0] STAT_SCLLOW = 8'h78;
  localparam logic [7:0] STAT_ARB    = 8'h38;
  localparam logic [7:0] STAT_START  = 8'h08;
  localparam logic [7:0] STAT_RSTART = 8'h10;

  // ----------------------------------------------------------------
  // register map (byte addresses) and fields
  // ----------------------------------------------------------------
  localparam logic [4:0] ADR_CTRL  = 5'h00;
  localparam logic [4:0] ADR_STAT  = 5'h04;
  localparam logic [4:0] ADR_COUNT = 5'h08;
  localparam logic [4:0] ADR_TOUT  = 5'h0C;
  localparam logic [4:0] ADR_OWN   = 5'h10;
  localparam logic [4:0] ADR_SWRST = 5'h14;
  localparam int CTL_STA = 0;
  localparam int CTL_STO = 1;
  localparam int CTL_SI  = 2;
  localparam int CTL_AA  = 3;
  localparam int CTL_GC  = 4;
  localparam logic [6:0] BC_MIN    = 7'h01;
  localparam logic [6:0] BC_MAX    = 7'h44;
  localparam logic [7:0] SWRST_KEY = 8'hA5;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [6:0] BC_RST   = 7'h01;
  localparam logic [7:0] TOUT_RST = 8'hFF;
  localparam logic [6:0] OWN_RST  = 7'h00;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS    = 4;
  localparam int T_HALF_NS = 500;
  localparam logic [23:0] HALF_CYC = 24'((T_HALF_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [4:0]  REC_EDGES = 5'd18;
  localparam logic [3:0]  ADDR_BITS = 4'd8;

  typedef enum logic [3:0] {
    S_IDLE, S_WAIT, S_STA, S_MST, S_STO1, S_STO2, S_RS1, S_RS2, S_RS3,
    S_ARB, S_REC, S_RP1, S_RP2, S_RP3, S_ERR
  } ibr_state_t;

  // two bus lines carried together
  typedef struct packed {
    logic scl;
    logic sda;
  } ibr_line_t;

endpackage

// ==== design/ibr_sync.sv ====
// three-stage synchroniser; output follows once stages two and three agree
module ibr_sync import ibr_pkg::*; #(
  parameter int W = 2
) (
  input  wire logic         clk_i, // core clock
  input  wire logic         rst_i, // sync reset, high
  input  wire logic [W-1:0] d_i,   // asynchronous lines
  output logic      [W-1:0] q_o    // filtered lines
);

  typedef struct packed {
    logic [W-1:0] f1;
    logic [W-1:0] f2;
    logic [W-1:0] f3;
    logic [W-1:0] q;
  } ibr_sync_st_t;

  ibr_sync_st_t q, d;

  // ----------------------------------------------------------------
  // next state: idle lines reset high so no false edge at release
  // ----------------------------------------------------------------
  always_comb begin
    d    = q;
    d.f1 = d_i;
    d.f2 = q.f1;
    d.f3 = q.f2;
    for (int i = 0; i < W; i++) begin
      if (q.f2[i] == q.f3[i]) begin
        d.q[i] = q.f3[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '1;
    end else begin
      q <= d;
    end
  end

  assign q_o = q.q;

endmodule // ibr_sync

// ==== design/ibr_ctrl.sv ====
// Function
// - after reset or STOP, not in transfer: status F8h with interrupt flag clear
// - in F8h with start request and flag clear: become master, send START
// - idle without acknowledge: ignore own address, still answer general call if enabled
// - idle with acknowledge: answer own address, general call when enabled
// - illegal byte count value gives status FCh; host writes 1 to 68
// - START or STOP inside address, data or acknowledge bit is bus error 00h
// - from 00h, 70h, 78h only hardware or software reset recovers
// - status 70h means data line low while master tries START
// - clock line low for time-out period gives bus error 78h
// - other master's repeated START before ours is adopted; address follows
// - arbitration loss reported as 38h
// - 38h left only by time-out, reset, foreign STOP or bus error as addressed slave
// - start request pending in arbitration-lost: auto START when bus free, 08h
// - start pending, bus busy, lines idle for time-out: send START anyway
// - data line held low at START: nine clock pulses then STOP
// - data line freed after recovery: normal START, state 08h
// - data line still low: status 70h, interrupt, release both lines
// - forced access or repeated START on stuck data line uses same recovery
// - illegal START or STOP matters only when master or addressed slave
// - bus error releases lines, sets interrupt flag, loads 00h
module ibr_ctrl import ibr_pkg::*; #(
  parameter logic [15:0] TO_UNIT = 16'h0100  // core cycles per time-out step
) (
  input  wire logic       clk_i,    // 250 MHz core clock
  input  wire logic       rst_i,    // sync reset, high
  input  wire logic       wb_cyc_i, // wishbone cycle
  input  wire logic       wb_stb_i, // wishbone strobe
  input  wire logic       wb_we_i,  // wishbone write
  input  wire logic [4:0] wb_adr_i, // byte address
  input  wire logic       wb_sel_i, // byte lane select
  input  wire logic [7:0] wb_dat_i, // write data
  output logic      [7:0] wb_dat_o, // read data
  output logic            wb_ack_o, // access done
  input  wire logic       scl_i,    // clock line level
  output logic            scl_o,    // clock line drive value (low)
  output logic            scl_oe_o, // pull clock line low
  input  wire logic       sda_i,    // data line level
  output logic            sda_o,    // data line drive value (low)
  output logic            sda_oe_o, // pull data line low
  output logic            int_o     // serial interrupt flag
);

  typedef struct packed {
    ibr_state_t  st;
    logic [7:0]  stat;
    logic        start_request;
    logic        stop_request;
    logic        si;
    logic        aa;
    logic        gc;
    logic [6:0]  bc;
    logic [7:0]  tout;
    logic [6:0]  own;
    logic [23:0] tmr;
    logic [23:0] tocnt;
    logic [4:0]  nclk;
    logic        scl_oe;
    logic        sda_oe;
    ibr_line_t   lp;
    logic        busy;
    logic        listen;
    logic        addressed;
    logic        sack;
    logic [3:0]  bitcnt;
    logic [7:0]  shr;
    logic        ack_q;
    logic [7:0]  dat;
    logic        swrst;
  } ibr_ctrl_st_t;

  localparam ibr_ctrl_st_t RST_VAL = '{
    st: S_IDLE, stat: STAT_IDLE, bc: BC_RST, tout: TOUT_RST, own: OWN_RST,
    lp: '1, default: '0};

  ibr_ctrl_st_t q, d;
  ibr_line_t    ln;
  logic         start_det, stop_det, scl_rise, scl_fall, to_hit, master;
  logic         want_start, berr;
  logic [23:0]  to_lim;
  logic [7:0]   addr_byte;

  // ----------------------------------------------------------------
  // line synchroniser and condition detection
  // ----------------------------------------------------------------
  ibr_sync #(.W(2)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({scl_i, sda_i}),
    .q_o   (ln)
  );

  assign start_det = ln.scl & q.lp.scl & q.lp.sda & ~ln.sda;
  assign stop_det  = ln.scl & q.lp.scl & ~q.lp.sda & ln.sda;
  assign scl_rise  = ln.scl & ~q.lp.scl;
  assign scl_fall  = ~ln.scl & q.lp.scl;
  assign master    = ~(q.st inside {S_IDLE, S_WAIT, S_ARB, S_ERR});
  assign addr_byte = {q.shr[6:0], ln.sda};
  // a zero time-out register disables both time-out uses
  assign to_lim = 24'(q.tout) * 24'(TO_UNIT);
  assign to_hit = (q.tout != 8'h00) && (q.tocnt >= to_lim);
  // bus error only counts while we take part in a transfer; the first bit slot of a
  // byte is where a legal STOP or repeated START sits, later bits and the ack are not
  assign berr = (start_det | stop_det) & q.st != S_ERR &
                ((q.addressed & q.bitcnt > 4'd1) | q.st == S_MST);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d          = q;
    want_start = 1'b0;
    d.lp       = ln;
    d.ack_q    = 1'b0;
    if (q.tmr != 24'd0) begin
      d.tmr = q.tmr - 24'd1;
    end
    if (start_det) begin
      d.busy = 1'b1;
    end
    if (stop_det) begin
      d.busy = 1'b0;
    end

    // time-out counter: stuck clock, or idle lines while waiting for the bus
    if ((!ln.scl && !q.scl_oe) ||
        (ln.scl && ln.sda && (q.st == S_WAIT || q.st == S_ARB))) begin
      if (!to_hit) begin
        d.tocnt = q.tocnt + 24'd1;
      end
    end else begin
      d.tocnt = 24'd0;
    end

    // wishbone slave: one wait state, unmapped reads zero
    if (wb_cyc_i && wb_stb_i && !q.ack_q) begin
      d.ack_q = 1'b1;
      d.dat   = 8'h00;
      if (wb_adr_i == ADR_CTRL) begin
        d.dat = {3'h0, q.gc, q.aa, q.si, q.stop_request, q.start_request};
        // control writes are dead once a fatal code is loaded
        if (wb_we_i && wb_sel_i && q.st != S_ERR) begin
          d.start_request = wb_dat_i[CTL_STA];
          d.stop_request = wb_dat_i[CTL_STO];
          d.aa  = wb_dat_i[CTL_AA];
          d.gc  = wb_dat_i[CTL_GC];
          if (!wb_dat_i[CTL_SI]) begin
            d.si = 1'b0;
          end
        end
      end else if (wb_adr_i == ADR_STAT) begin
        d.dat = q.stat;
      end else if (wb_adr_i == ADR_COUNT) begin
        d.dat = {1'b0, q.bc};
        if (wb_we_i && wb_sel_i && q.st != S_ERR) begin
          d.bc = wb_dat_i[6:0];
          if (wb_dat_i[6:0] < BC_MIN || wb_dat_i[6:0] > BC_MAX) begin
            if (q.stat == STAT_IDLE) begin
              d.stat = STAT_BADCNT;
            end
          end else if (q.stat == STAT_BADCNT) begin
            d.stat = STAT_IDLE;
          end
        end
      end else if (wb_adr_i == ADR_TOUT) begin
        d.dat = q.tout;
        if (wb_we_i && wb_sel_i) begin
          d.tout = wb_dat_i;
        end
      end else if (wb_adr_i == ADR_OWN) begin
        d.dat = {1'b0, q.own};
        if (wb_we_i && wb_sel_i) begin
          d.own = wb_dat_i[6:0];
        end
      end else if (wb_adr_i == ADR_SWRST) begin
        if (wb_we_i && wb_sel_i && wb_dat_i == SWRST_KEY) begin
          d.swrst = 1'b1;
        end
      end
    end

    // address listener for slave recognition
    if (start_det && !master) begin
      d.listen    = 1'b1;
      d.addressed = 1'b0;
      d.bitcnt    = 4'd0;
    end else if (stop_det) begin
      d.listen    = 1'b0;
      d.addressed = 1'b0;
      d.sack      = 1'b0;
      if (q.st == S_IDLE && q.stat == STAT_IDLE) begin
        d.stat = STAT_IDLE;
      end
    end else if (q.listen && scl_rise) begin
      d.shr    = addr_byte;
      // counts 1 to 9 per byte, nine being the ack slot
      d.bitcnt = (q.bitcnt == ADDR_BITS + 4'd1) ? 4'd1 : q.bitcnt + 4'd1;
      if (q.bitcnt == ADDR_BITS - 4'd1 && !q.addressed) begin
        if ((q.aa && addr_byte[7:1] == q.own) ||
            (q.gc && addr_byte == 8'h00)) begin
          d.addressed = 1'b1;
          d.sack      = 1'b1;
        end else begin
          d.listen = 1'b0;
        end
      end
    end else if (q.listen && scl_fall) begin
      // pull data low through the ninth bit only
      if (q.sack && q.bitcnt == ADDR_BITS) begin
        d.sda_oe = 1'b1;
      end else if (q.sack && q.bitcnt == ADDR_BITS + 4'd1) begin
        d.sda_oe = 1'b0;
        d.sack   = 1'b0;
      end
    end

    // master sequencer
    case (q.st)
      S_IDLE: begin
        if (q.start_request && !q.si && q.stat == STAT_IDLE && !q.listen) begin
          if (q.busy) begin
            d.st = S_WAIT;
          end else begin
            want_start = 1'b1;
          end
        end
      end
      S_WAIT: begin
        if (!q.start_request) begin
          d.st = S_IDLE;
        end else if (!q.busy) begin
          want_start = 1'b1;
        end else if (to_hit && ln.scl) begin
          d.busy     = 1'b0;
          want_start = 1'b1;
        end
      end
      S_STA: begin
        if (q.tmr == 24'd0) begin
          if (!ln.scl) begin
            // someone else is already clocking: we lost the bus
            d.st     = S_ARB;
            d.stat   = STAT_ARB;
            d.si     = 1'b1;
            d.sda_oe = 1'b0;
          end else begin
            d.scl_oe = 1'b1;
            d.st     = S_MST;
            d.stat   = STAT_START;
            d.si     = 1'b1;
            d.start_request    = 1'b0;
          end
        end
      end
      S_MST: begin
        if (!q.si && q.stop_request) begin
          d.sda_oe = 1'b1;
          d.tmr    = HALF_CYC;
          d.st     = S_STO1;
        end else if (!q.si && q.start_request) begin
          d.sda_oe = 1'b0;
          d.tmr    = HALF_CYC;
          d.st     = S_RS1;
        end
      end
      S_STO1: begin
        if (q.tmr == 24'd0) begin
          d.scl_oe = 1'b0;
          d.tmr    = HALF_CYC;
          d.st     = S_STO2;
        end
      end
      S_STO2: begin
        if (q.tmr == 24'd0) begin
          d.sda_oe = 1'b0;
          d.stop_request    = 1'b0;
          d.stat   = STAT_IDLE;
          d.st     = S_IDLE;
        end
      end
      S_RS1: begin
        if (q.tmr == 24'd0) begin
          d.scl_oe = 1'b0;
          d.tmr    = HALF_CYC;
          d.st     = S_RS2;
        end
      end
      S_RS2: begin
        if (start_det) begin
          // another master's repeated START stands in for ours
          d.scl_oe = 1'b1;
          d.st     = S_MST;
          d.stat   = STAT_RSTART;
          d.si     = 1'b1;
          d.start_request    = 1'b0;
        end else if (q.tmr == 24'd0) begin
          if (!ln.sda) begin
            want_start = 1'b1;
          end else begin
            d.sda_oe = 1'b1;
            d.tmr    = HALF_CYC;
            d.st     = S_RS3;
          end
        end
      end
      S_RS3: begin
        if (q.tmr == 24'd0) begin
          d.scl_oe = 1'b1;
          d.st     = S_MST;
          d.stat   = STAT_RSTART;
          d.si     = 1'b1;
          d.start_request    = 1'b0;
        end
      end
      S_ARB: begin
        // a foreign STOP or idle time-out ends this state; stuck clock or bus error as addressed slave goes to S_ERR
        if (stop_det || (to_hit && ln.scl)) begin
          d.busy = 1'b0;
          if (q.start_request) begin
            want_start = 1'b1;
          end else begin
            d.st   = S_IDLE;
            d.stat = STAT_IDLE;
          end
        end
      end
      S_REC: begin
        if (q.tmr == 24'd0) begin
          d.tmr = HALF_CYC;
          if (q.nclk == REC_EDGES) begin
            d.scl_oe = 1'b1;
            d.sda_oe = 1'b1;
            d.st     = S_RP1;
          end else begin
            d.scl_oe = ~q.scl_oe;
            d.nclk   = q.nclk + 5'd1;
          end
        end
      end
      S_RP1: begin
        if (q.tmr == 24'd0) begin
          d.scl_oe = 1'b0;
          d.tmr    = HALF_CYC;
          d.st     = S_RP2;
        end
      end
      S_RP2: begin
        if (q.tmr == 24'd0) begin
          d.sda_oe = 1'b0;
          d.tmr    = HALF_CYC;
          d.st     = S_RP3;
        end
      end
      S_RP3: begin
        if (q.tmr == 24'd0) begin
          if (ln.sda) begin
            want_start = 1'b1;
          end else begin
            d.st     = S_ERR;
            d.stat   = STAT_SDALOW;
            d.si     = 1'b1;
            d.scl_oe = 1'b0;
            d.sda_oe = 1'b0;
          end
        end
      end
      default: begin
        d.st = S_ERR;
      end
    endcase

    // a stuck data line turns any START attempt into clock recovery
    if (want_start) begin
      d.tmr = HALF_CYC;
      if (!ln.sda) begin
        d.st     = S_REC;
        d.nclk   = 5'd0;
        d.scl_oe = 1'b0;
        d.sda_oe = 1'b0;
      end else begin
        d.st     = S_STA;
        d.sda_oe = 1'b1;
        d.scl_oe = 1'b0;
      end
    end

    // fatal bus errors override everything, set wins over a clear of the flag
    if (berr) begin
      d.st     = S_ERR;
      d.stat   = STAT_BERR;
      d.si     = 1'b1;
      d.scl_oe = 1'b0;
      d.sda_oe = 1'b0;
      d.listen = 1'b0;
      d.sack   = 1'b0;
    end else if (to_hit && !ln.scl && q.st != S_ERR) begin
      d.st     = S_ERR;
      d.stat   = STAT_SCLLOW;
      d.si     = 1'b1;
      d.scl_oe = 1'b0;
      d.sda_oe = 1'b0;
      d.listen = 1'b0;
      d.sack   = 1'b0;
    end
  end

  // software reset takes effect one cycle after the key is written
  always_ff @(posedge clk_i) begin
    if (rst_i || q.swrst) begin
      q <= RST_VAL;
    end else begin
      q <= d;
    end
  end

  assign wb_dat_o = q.dat;
  assign wb_ack_o = q.ack_q;
  assign scl_oe_o = q.scl_oe;
  assign sda_oe_o = q.sda_oe;
  assign int_o    = q.si;
  assign scl_o    = 1'b0;
  assign sda_o    = 1'b0;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_idle_rst;
    $past(rst_i) |-> q.stat == STAT_IDLE && !q.si && q.st == S_IDLE;
  endproperty
  a_idle_rst: assert property (p_idle_rst) else $error("not idle after reset");

  property p_go_start;
    q.st == S_IDLE && q.start_request && !q.si && q.stat == STAT_IDLE && !q.busy &&
      !q.listen && !berr && ln.scl && !q.swrst |=> q.st inside {S_STA, S_REC};
  endproperty
  a_go_start: assert property (p_go_start) else $error("start request ignored");

  property p_badcnt;
    wb_cyc_i && wb_stb_i && !q.ack_q && wb_we_i && wb_sel_i && wb_adr_i == ADR_COUNT &&
      q.stat == STAT_IDLE && q.st != S_ERR && wb_dat_i[6:0] == 7'h00 && !berr && !q.swrst
      |=> q.stat == STAT_BADCNT;
  endproperty
  a_badcnt: assert property (p_badcnt) else $error("illegal count not flagged");

  property p_berr;
    berr && !q.swrst |=> q.stat == STAT_BERR && int_o && !scl_oe_o && !sda_oe_o
      ##1 q.st == S_ERR;
  endproperty
  a_berr: assert property (p_berr) else $error("bus error not handled");

  property p_err_sticky;
    q.st == S_ERR && !q.swrst |=> q.st == S_ERR && q.stat == $past(q.stat);
  endproperty
  a_err_sticky: assert property (p_err_sticky) else $error("left fatal state");

  property p_scl_stuck;
    to_hit && !ln.scl && q.st != S_ERR && !berr && !q.swrst |=>
      q.stat == STAT_SCLLOW && int_o && !scl_oe_o;
  endproperty
  a_scl_stuck: assert property (p_scl_stuck) else $error("stuck clock missed");

  property p_adopt;
    q.st == S_RS2 && start_det && !q.swrst && !(to_hit && !ln.scl) |=>
      q.st == S_MST && q.stat == STAT_RSTART;
  endproperty
  a_adopt: assert property (p_adopt) else $error("foreign restart not adopted");

  property p_arb_hold;
    q.st == S_ARB && !stop_det && !to_hit && !q.swrst |=> q.st == S_ARB && q.stat == STAT_ARB;
  endproperty
  a_arb_hold: assert property (p_arb_hold) else $error("left arbitration state");

  property p_nine;
    $rose(q.st == S_RP1) |-> q.nclk == REC_EDGES && scl_oe_o && sda_oe_o;
  endproperty
  a_nine: assert property (p_nine) else $error("recovery clock count wrong");

  property p_rec_fail;
    q.st == S_RP3 && q.tmr == 24'd0 && !ln.sda && !q.swrst |=>
      q.stat == STAT_SDALOW && int_o && !scl_oe_o && !sda_oe_o;
  endproperty
  a_rec_fail: assert property (p_rec_fail) else $error("stuck data not reported");

  c_master: cover property (q.st == S_STA ##1 q.st == S_MST);
  c_arb:    cover property (q.st == S_ARB ##1 q.st == S_STA);
  c_rec:    cover property (q.st == S_RP3 ##1 q.st == S_STA);
  c_slave:  cover property ($rose(q.addressed));

endmodule // ibr_ctrl

// ==== sim/ibr_bus_model.sv ====
// far side of the two bus lines: pull-ups, jamming devices and a foreign master
module ibr_bus_model (
  input  wire logic scl_oe_i,   // controller pulls clock low
  input  wire logic sda_oe_i,   // controller pulls data low
  input  wire logic hold_scl_i, // far side jams clock low
  input  wire logic hold_sda_i, // far side jams data low
  output logic      scl_o,      // resolved clock line
  output logic      sda_o,      // resolved data line
  output int        falls_o     // clock falling edges seen
);
  timeunit 1ns;
  timeprecision 100ps;
  logic drv_scl = 1'b0;
  logic drv_sda = 1'b0;

  // ------------------------------------------------------------
  // wired-and lines; a released line returns to its pull-up level
  // ------------------------------------------------------------
  assign scl_o = ~(scl_oe_i | hold_scl_i | drv_scl);
  assign sda_o = ~(sda_oe_i | hold_sda_i | drv_sda);

  // pulses counted here so the recovery train can be judged
  initial falls_o = 0;
  always @(negedge scl_o) begin
    falls_o++;
  end

  // foreign master: START, address byte msb first, ack bit, extra data clocks, STOP
  task automatic frame(input logic [7:0] b, input int extra, output logic ack);
    #1 drv_sda = 1'b1;
    #40 drv_scl = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      #20 drv_sda = ~b[i];
      #20 drv_scl = 1'b0;
      #40 drv_scl = 1'b1;
    end
    #20 drv_sda = 1'b0;
    #20 drv_scl = 1'b0;
    #20 ack = sda_o;
    #20 drv_scl = 1'b1;
    for (int i = 0; i < extra; i++) begin
      #40 drv_scl = 1'b0;
      #40 drv_scl = 1'b1;
    end
    #20 drv_sda = 1'b1;
    #20 drv_scl = 1'b0;
    #40 drv_sda = 1'b0;
    #40;
  endtask
endmodule // ibr_bus_model

// ==== sim/ibr_ctrl_tb.sv ====
module ibr_ctrl_tb import ibr_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       cyc   = 1'b0;
  logic       stb   = 1'b0;
  logic       we    = 1'b0;
  logic       sel   = 1'b0;
  logic       hold_scl = 1'b0;
  logic       hold_sda = 1'b0;
  logic [4:0] adr   = 5'h00;
  logic [7:0] wdat  = 8'h00;
  logic [7:0] rd, dat_o;
  logic       ack, scl, sda, scl_oe, sda_oe, int_o;
  int         bad_count = 0;
  int         samples_checked = 0;
  int         falls;

  ibr_ctrl #(.TO_UNIT(16'h0004)) ibr_ctrl_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .scl_i(scl), .scl_o(), .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe),
    .int_o(int_o));
  ibr_bus_model ibr_bus_model_inst (
    .scl_oe_i(scl_oe), .sda_oe_i(sda_oe), .hold_scl_i(hold_scl), .hold_sda_i(hold_sda),
    .scl_o(scl), .sda_o(sda), .falls_o(falls));

  always #2 clk_i = ~clk_i;

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic end_sim();
    if (bad_count == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // classic cycle: hold everything until ack is sampled high at an edge
  task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 1'b1;
    @(posedge clk_i);
    while (ack !== 1'b1) begin
      @(posedge clk_i);
    end
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic rdc(input logic [4:0] a, input logic [7:0] exp);
    wb(1'b0, a, 8'h00);
    chk(rd, exp);
  endtask

  // bounded wait; the caller then checks the flag or the status register
  task automatic wait_int(input int lim);
    for (int n = 0; n < lim && int_o !== 1'b1; n++) @(posedge clk_i);
  endtask

  task automatic do_reset();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask

  // data line jammed while the clock is low, so the bus never sees a START
  task automatic jam_sda();
    do_reset();
    wb(1'b1, ADR_TOUT, 8'h10);
    hold_scl <= 1'b1;
    repeat (4) @(posedge clk_i);
    hold_sda <= 1'b1;
    repeat (4) @(posedge clk_i);
    hold_scl <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic s_idle_count();
    logic [7:0] v [4] = '{8'h00, 8'h44, 8'h45, 8'h01};
    logic [7:0] e [4] = '{STAT_BADCNT, STAT_IDLE, STAT_BADCNT, STAT_IDLE};
    rdc(ADR_STAT, STAT_IDLE);
    chk({7'h00, int_o}, 8'h00);
    rdc(5'h1C, 8'h00); // unmapped place reads zero
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, ADR_COUNT, v[i]);
      rdc(ADR_STAT, e[i]);
    end
  endtask

  task automatic s_start_stop();
    wb(1'b1, ADR_TOUT, 8'h10);
    wb(1'b1, ADR_CTRL, 8'h01);
    wait_int(1000);
    chk({7'h00, int_o}, 8'h01);
    rdc(ADR_STAT, STAT_START);
    wb(1'b1, ADR_CTRL, 8'h02);
    for (int n = 0; n < 200 && rd !== STAT_IDLE; n++) wb(1'b0, ADR_STAT, 8'h00);
    chk(rd, STAT_IDLE);
    chk({7'h00, int_o}, 8'h00);
  endtask

  // own address without and with acknowledge, general call with enable;
  // a STOP two data clocks in is an error only for an addressed slave
  task automatic s_addr();
    logic [7:0] c [4] = '{8'h00, 8'h10, 8'h08, 8'h08};
    logic [7:0] b [4] = '{8'h54, 8'h00, 8'h54, 8'h54};
    logic       e [4] = '{1'b1, 1'b0, 1'b0, 1'b0};
    int         x [4] = '{2, 0, 0, 2};
    logic [7:0] s [4] = '{STAT_IDLE, STAT_IDLE, STAT_IDLE, STAT_BERR};
    logic       a;
    for (int i = 0; i < 4; i++) begin
      do_reset();
      wb(1'b1, ADR_OWN, 8'h2A);
      wb(1'b1, ADR_CTRL, c[i]);
      ibr_bus_model_inst.frame(b[i], x[i], a);
      chk({7'h00, a}, {7'h00, e[i]});
      rdc(ADR_STAT, s[i]);
      chk({7'h00, int_o}, {7'h00, s[i] == STAT_BERR});
      chk({6'h00, scl_oe, sda_oe}, 8'h00);
    end
  endtask

  // data line freed during the recovery train: a normal START follows
  task automatic s_sda_free();
    jam_sda();
    wb(1'b1, ADR_CTRL, 8'h01);
    repeat (1000) @(posedge clk_i);
    hold_sda <= 1'b0;
    wait_int(5000);
    rdc(ADR_STAT, STAT_START);
  endtask

  // jammed data line: start request, recovery train, then fatal until reset
  task automatic s_sda_low();
    int f0;
    jam_sda();
    f0 = falls;
    wb(1'b1, ADR_CTRL, 8'h01);
    wait_int(5000);
    rdc(ADR_STAT, STAT_SDALOW);
    chk({6'h00, scl_oe, sda_oe}, 8'h00);
    chk(8'((falls - f0) >= 9 && (falls - f0) <= 11), 8'h01);
    wb(1'b1, ADR_CTRL, 8'h01);
    wb(1'b1, ADR_COUNT, 8'h00);
    rdc(ADR_STAT, STAT_SDALOW);
    hold_sda <= 1'b0;
    wb(1'b1, ADR_SWRST, SWRST_KEY);
    repeat (2) @(posedge clk_i);
    rdc(ADR_STAT, STAT_IDLE);
    chk({7'h00, int_o}, 8'h00);
  endtask

  // jammed clock line with the reset time-out
  task automatic s_scl_low();
    hold_scl <= 1'b1;
    wait_int(3000);
    rdc(ADR_STAT, STAT_SCLLOW);
    wb(1'b1, ADR_CTRL, 8'h01);
    rdc(ADR_STAT, STAT_SCLLOW);
    hold_scl <= 1'b0;
    do_reset();
    rdc(ADR_STAT, STAT_IDLE);
  endtask

  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    s_idle_count();
    s_start_stop();
    s_addr();
    s_sda_free();
    s_sda_low();
    s_scl_low();
    end_sim();
  end

  initial begin
    #300000;
    bad_count++;
    end_sim();
  end
endmodule // ibr_ctrl_tb
